// *** pkg/vmc_pkg.sv ***
// package for the virtualization mode control block
// assumes one core clock domain; instructions arrive pre-decoded
`default_nettype none
package vmc_pkg;
  // instruction opcodes as delivered by the core decoder
  typedef enum logic [3:0] {
    VMC_OP_NONE,
    VMC_OP_ENTER,
    VMC_OP_LEAVE,
    VMC_OP_FIRST_ENTRY,
    VMC_OP_REPEAT_ENTRY,
    VMC_OP_CALL_MONITOR,
    VMC_OP_LOAD_PTR,
    VMC_OP_STORE_PTR,
    VMC_OP_READ_FIELD,
    VMC_OP_WRITE_FIELD,
    VMC_OP_FLUSH,
    VMC_OP_FEATURE_QUERY
  } vmc_op_t;
  // operating modes of the logical processor
  typedef enum logic [1:0] {
    VMC_MODE_OFF,
    VMC_MODE_HOST,
    VMC_MODE_GUEST
  } vmc_mode_t;
  // widths and field positions
  localparam int VMC_PTR_W = 64;
  localparam int VMC_CR4_W = 32;
  localparam int VMC_CR4_VIRT_EN_BIT = 13;
  localparam int VMC_FEAT_BIT = 5;
  localparam int VMC_FEAT_LEAF = 1;
  localparam int VMC_CAP_W = 64;
  localparam int VMC_CAP_N = 4;
  // reset values
  localparam logic [63:0] VMC_PTR_RST = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] VMC_CAP_DFLT = 64'h0000_0000_0000_0000;
endpackage
`default_nettype wire

// *** hw/vmc_cap_regs.sv ***
// read-only capability register bank, one entry per index
// assumes the index comes from the same clock domain
`default_nettype none
module vmc_cap_regs #(
  parameter logic [63:0] CAP_VAL0 = vmc_pkg::VMC_CAP_DFLT,
  parameter logic [63:0] CAP_VAL1 = vmc_pkg::VMC_CAP_DFLT,
  parameter logic [63:0] CAP_VAL2 = vmc_pkg::VMC_CAP_DFLT,
  parameter logic [63:0] CAP_VAL3 = vmc_pkg::VMC_CAP_DFLT
) (
  // index in
  input wire logic [1:0] cap_idx,
  // value out
  output logic [63:0] cap_val
);
  // constant table, software can never write it
  logic [63:0] cap_tab [vmc_pkg::VMC_CAP_N];
  assign cap_tab[0] = CAP_VAL0;
  assign cap_tab[1] = CAP_VAL1;
  assign cap_tab[2] = CAP_VAL2;
  assign cap_tab[3] = CAP_VAL3;
  assign cap_val = cap_tab[cap_idx];
endmodule
`default_nettype wire

// *** hw/vmc_mode_ctrl.sv ***
// virtualization mode control: mode tracking, transitions, pointer
// assumes a decoder issuing one-cycle instruction strobes on clock
`default_nettype none
module vmc_mode_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // instruction strobe and operands
  input wire logic instr_valid,
  input wire vmc_pkg::vmc_op_t instr_op,
  input wire logic [63:0] instr_operand,
  input wire logic [31:0] query_leaf,
  input wire logic [1:0] cap_idx,
  // core state
  input wire logic [31:0] cr4_value,
  input wire logic [1:0] current_privilege,
  // guest exit events and hypervisor entry point
  input wire logic guest_event,
  input wire logic [63:0] exit_entry_point,
  // results
  output logic done_r,
  output logic fault_r,
  output logic [63:0] result_r,
  output logic in_virt_r,
  output logic restrict_r,
  output logic guest_entry_r,
  output logic guest_exit_r,
  output logic redirect_r,
  output logic [63:0] redirect_pc_r,
  output logic ctl_access_r,
  output logic [63:0] ctl_addr_r
);
  // mode state; guest is never exposed as a readable bit
  vmc_pkg::vmc_mode_t mode_r, mode_nxt;
  // current control-structure pointer
  logic [63:0] ptr_r, ptr_nxt;
  // next values of the outputs
  logic done_nxt, fault_nxt, in_virt_nxt, restrict_nxt;
  logic guest_entry_nxt, guest_exit_nxt, redirect_nxt, ctl_access_nxt;
  logic [63:0] result_nxt, redirect_pc_nxt, ctl_addr_nxt;
  // capability bank output
  logic [63:0] cap_val;
  // an instruction issued in this cycle
  logic any_instr;
  assign any_instr = instr_valid && (instr_op != vmc_pkg::VMC_OP_NONE);

  // capability values are fixed by integration
  vmc_cap_regs u_cap (
    .cap_idx(cap_idx),
    .cap_val(cap_val)
  );

  // next-state computation for mode, pointer and outputs
  always_comb
  begin
    mode_nxt = mode_r;
    ptr_nxt = ptr_r;
    done_nxt = 1'b0;
    fault_nxt = 1'b0;
    result_nxt = 64'h0;
    guest_entry_nxt = 1'b0;
    guest_exit_nxt = 1'b0;
    redirect_nxt = 1'b0;
    redirect_pc_nxt = redirect_pc_r;
    ctl_access_nxt = 1'b0;
    ctl_addr_nxt = ctl_addr_r;
    if (mode_r == vmc_pkg::VMC_MODE_GUEST)
    begin
      // guest mode: calls and events leave to hypervisor, whatever
      // the privilege level; any other instruction exits in the branch below
      if (guest_event || (any_instr &&
          instr_op == vmc_pkg::VMC_OP_CALL_MONITOR))
      begin
        mode_nxt = vmc_pkg::VMC_MODE_HOST;
        guest_exit_nxt = 1'b1;
        redirect_nxt = 1'b1;
        redirect_pc_nxt = exit_entry_point;
        ctl_access_nxt = 1'b1;
        ctl_addr_nxt = ptr_r;
        done_nxt = any_instr;
      end
      else if (any_instr)
      begin
        // other virtualization instructions also exit in guest mode
        mode_nxt = vmc_pkg::VMC_MODE_HOST;
        guest_exit_nxt = 1'b1;
        redirect_nxt = 1'b1;
        redirect_pc_nxt = exit_entry_point;
        ctl_access_nxt = 1'b1;
        ctl_addr_nxt = ptr_r;
        done_nxt = 1'b1;
      end
    end
    else if (any_instr)
    begin
      done_nxt = 1'b1;
      case (instr_op)
        vmc_pkg::VMC_OP_FEATURE_QUERY:
        begin
          // support bit only on the documented leaf
          if (query_leaf == 32'(vmc_pkg::VMC_FEAT_LEAF))
            result_nxt[vmc_pkg::VMC_FEAT_BIT] = 1'b1;
        end
        vmc_pkg::VMC_OP_ENTER:
        begin
          if (!cr4_value[vmc_pkg::VMC_CR4_VIRT_EN_BIT])
            fault_nxt = 1'b1;
          else if (mode_r == vmc_pkg::VMC_MODE_OFF)
            mode_nxt = vmc_pkg::VMC_MODE_HOST;
          else
            fault_nxt = 1'b1;
        end
        vmc_pkg::VMC_OP_LEAVE:
        begin
          if (mode_r == vmc_pkg::VMC_MODE_HOST)
            mode_nxt = vmc_pkg::VMC_MODE_OFF;
          else
            fault_nxt = 1'b1;
        end
        vmc_pkg::VMC_OP_FIRST_ENTRY, vmc_pkg::VMC_OP_REPEAT_ENTRY:
        begin
          if (mode_r == vmc_pkg::VMC_MODE_HOST)
          begin
            mode_nxt = vmc_pkg::VMC_MODE_GUEST;
            guest_entry_nxt = 1'b1;
            ctl_access_nxt = 1'b1;
            ctl_addr_nxt = ptr_r;
          end
          else
            fault_nxt = 1'b1;
        end
        vmc_pkg::VMC_OP_LOAD_PTR:
        begin
          if (mode_r == vmc_pkg::VMC_MODE_HOST)
            ptr_nxt = instr_operand;
          else
            fault_nxt = 1'b1;
        end
        vmc_pkg::VMC_OP_STORE_PTR:
        begin
          if (mode_r == vmc_pkg::VMC_MODE_HOST)
            result_nxt = ptr_r;
          else
            fault_nxt = 1'b1;
        end
        vmc_pkg::VMC_OP_READ_FIELD, vmc_pkg::VMC_OP_WRITE_FIELD,
        vmc_pkg::VMC_OP_FLUSH:
        begin
          // field access goes to the structure; host only
          if (mode_r == vmc_pkg::VMC_MODE_HOST)
          begin
            ctl_access_nxt = 1'b1;
            ctl_addr_nxt = (instr_op == vmc_pkg::VMC_OP_FLUSH) ?
                           instr_operand : ptr_r;
            if (instr_op == vmc_pkg::VMC_OP_READ_FIELD)
              result_nxt = cap_val; // capability readback
          end
          else
            fault_nxt = 1'b1;
        end
        default:
        begin
          // calls outside guest mode are not available
          fault_nxt = 1'b1;
        end
      endcase
    end
    // derived mode outputs; guest status is only a restrict control
    in_virt_nxt = (mode_nxt != vmc_pkg::VMC_MODE_OFF);
    restrict_nxt = (mode_nxt == vmc_pkg::VMC_MODE_GUEST);
  end

  // register stage; all outputs come straight from flops
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r <= vmc_pkg::VMC_MODE_OFF;
      ptr_r <= vmc_pkg::VMC_PTR_RST;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      result_r <= 64'h0;
      in_virt_r <= 1'b0;
      restrict_r <= 1'b0;
      guest_entry_r <= 1'b0;
      guest_exit_r <= 1'b0;
      redirect_r <= 1'b0;
      redirect_pc_r <= 64'h0;
      ctl_access_r <= 1'b0;
      ctl_addr_r <= 64'h0;
    end
    else
    begin
      mode_r <= mode_nxt;
      ptr_r <= ptr_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      result_r <= result_nxt;
      in_virt_r <= in_virt_nxt;
      restrict_r <= restrict_nxt;
      guest_entry_r <= guest_entry_nxt;
      guest_exit_r <= guest_exit_nxt;
      redirect_r <= redirect_nxt;
      redirect_pc_r <= redirect_pc_nxt;
      ctl_access_r <= ctl_access_nxt;
      ctl_addr_r <= ctl_addr_nxt;
    end
  end

  // one clock and one reset for every check below
  default clocking cb_core @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // named steps of an entry and an exit
  sequence s_host_entry;
    mode_r == vmc_pkg::VMC_MODE_HOST && instr_valid &&
      (instr_op == vmc_pkg::VMC_OP_FIRST_ENTRY ||
       instr_op == vmc_pkg::VMC_OP_REPEAT_ENTRY);
  endsequence
  sequence s_guest_leaves;
    mode_r == vmc_pkg::VMC_MODE_GUEST && guest_event;
  endsequence

  chk_entry_to_guest: assert property (
    s_host_entry |=> guest_entry_r && restrict_r && !fault_r)
    else $error("guest entry not taken");
  chk_exit_redirect: assert property (
    s_guest_leaves |=> guest_exit_r && redirect_r &&
      redirect_pc_r == $past(exit_entry_point) && !restrict_r)
    else $error("guest exit did not redirect");
  // a call at the top privilege level still leaves the guest
  chk_priv_exit: assert property (
    (mode_r == vmc_pkg::VMC_MODE_GUEST && any_instr &&
     instr_op == vmc_pkg::VMC_OP_CALL_MONITOR &&
     current_privilege == 2'h0)
      |=> guest_exit_r && done_r && !fault_r && !restrict_r)
    else $error("privileged guest call did not exit");
  // a refused enter leaves the mode as it was, host included
  chk_enter_fault: assert property (
    (instr_valid && instr_op == vmc_pkg::VMC_OP_ENTER &&
     mode_r != vmc_pkg::VMC_MODE_GUEST &&
     !cr4_value[vmc_pkg::VMC_CR4_VIRT_EN_BIT])
      |=> fault_r && in_virt_r == $past(in_virt_r))
    else $error("enter without enable did not fault");
  chk_enter_ok: assert property (
    (instr_valid && instr_op == vmc_pkg::VMC_OP_ENTER &&
     mode_r == vmc_pkg::VMC_MODE_OFF &&
     cr4_value[vmc_pkg::VMC_CR4_VIRT_EN_BIT])
      |=> in_virt_r && !restrict_r && !fault_r)
    else $error("enter did not start operation");
  chk_leave_ok: assert property (
    (instr_valid && instr_op == vmc_pkg::VMC_OP_LEAVE &&
     mode_r == vmc_pkg::VMC_MODE_HOST) |=> !in_virt_r)
    else $error("leave did not end operation");
  chk_ptr_stable: assert property (
    !(instr_valid && instr_op == vmc_pkg::VMC_OP_LOAD_PTR) |=>
      ptr_r == $past(ptr_r))
    else $error("pointer changed without load");
  chk_ptr_store: assert property (
    (instr_valid && instr_op == vmc_pkg::VMC_OP_STORE_PTR &&
     mode_r == vmc_pkg::VMC_MODE_HOST) |=> result_r == $past(ptr_r))
    else $error("store returned wrong pointer");
  chk_query_bit: assert property (
    (instr_valid && instr_op == vmc_pkg::VMC_OP_FEATURE_QUERY &&
     mode_r != vmc_pkg::VMC_MODE_GUEST &&
     query_leaf == 32'(vmc_pkg::VMC_FEAT_LEAF))
      |=> result_r[vmc_pkg::VMC_FEAT_BIT] && done_r)
    else $error("support bit not reported");
  chk_outside_fault: assert property (
    (instr_valid && mode_r == vmc_pkg::VMC_MODE_OFF &&
     (instr_op == vmc_pkg::VMC_OP_FIRST_ENTRY ||
      instr_op == vmc_pkg::VMC_OP_LOAD_PTR))
      |=> fault_r && !in_virt_r ##1 !guest_entry_r)
    else $error("outside instruction did not fault");
  chk_mode_excl: assert property (
    restrict_r |-> in_virt_r)
    else $error("guest outside virtualization");
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the virtualization mode control block
// assumes the design's own assertions sit inside the design files
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // clock and reset
  logic clock = 1'b0;
  logic rstn = 1'b0;
  // instruction side
  logic instr_valid = 1'b0;
  vmc_pkg::vmc_op_t instr_op = vmc_pkg::VMC_OP_NONE;
  logic [63:0] instr_operand = 64'h0;
  logic [31:0] query_leaf = 32'h0;
  logic [1:0] cap_idx = 2'h0;
  logic [31:0] cr4_value = 32'h0;
  logic [1:0] current_privilege = 2'h0;
  logic guest_event = 1'b0;
  logic [63:0] exit_entry_point = 64'h0;
  // design outputs
  logic done_r, fault_r, in_virt_r, restrict_r;
  logic guest_entry_r, guest_exit_r, redirect_r, ctl_access_r;
  logic [63:0] result_r, redirect_pc_r, ctl_addr_r;
  // tallies
  int errors = 0;
  int checked = 0;
  // pointer and entry point values, 4 KiB aligned
  localparam logic [63:0] PTR_A = 64'h0000_0012_3456_7000;
  localparam logic [63:0] EP_A = 64'h0000_0000_cafe_0000;

  vmc_mode_ctrl vmc_mode_ctrl_i (
    .clock(clock), .rstn(rstn), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_operand(instr_operand),
    .query_leaf(query_leaf), .cap_idx(cap_idx), .cr4_value(cr4_value),
    .current_privilege(current_privilege), .guest_event(guest_event),
    .exit_entry_point(exit_entry_point), .done_r(done_r),
    .fault_r(fault_r), .result_r(result_r), .in_virt_r(in_virt_r),
    .restrict_r(restrict_r), .guest_entry_r(guest_entry_r),
    .guest_exit_r(guest_exit_r), .redirect_r(redirect_r),
    .redirect_pc_r(redirect_pc_r), .ctl_access_r(ctl_access_r),
    .ctl_addr_r(ctl_addr_r)
  );

  // free-running core clock, 5 ns period
  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // compare one value; four-state so an unknown never matches
  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one instruction; outputs are looked at just after the answer edge
  task automatic issue(input vmc_pkg::vmc_op_t op, input logic [63:0] opd);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_operand <= opd;
    @(posedge clock);
    instr_valid <= 1'b0;
    instr_op <= vmc_pkg::VMC_OP_NONE;
    #1;
  endtask

  // every instruction but enter, query and field write is tried; each is refused while off
  task automatic test_off_faults();
    vmc_pkg::vmc_op_t ops[8] = '{vmc_pkg::VMC_OP_LEAVE,
      vmc_pkg::VMC_OP_FIRST_ENTRY, vmc_pkg::VMC_OP_REPEAT_ENTRY,
      vmc_pkg::VMC_OP_CALL_MONITOR, vmc_pkg::VMC_OP_LOAD_PTR,
      vmc_pkg::VMC_OP_STORE_PTR, vmc_pkg::VMC_OP_READ_FIELD,
      vmc_pkg::VMC_OP_FLUSH};
    chk({63'h0, in_virt_r}, 64'h0, "off after reset");
    foreach (ops[i])
    begin
      issue(ops[i], PTR_A);
      chk({62'h0, fault_r, in_virt_r}, 64'h2, "off refusal");
      chk({63'h0, guest_entry_r}, 64'h0, "no entry while off");
    end
    // enter with the enable bit clear is refused
    @(posedge clock);
    cr4_value <= 32'h0;
    issue(vmc_pkg::VMC_OP_ENTER, 64'h0);
    chk({62'h0, fault_r, in_virt_r}, 64'h2, "enter disabled");
  endtask

  // enter, then host-mode instructions and the pointer register
  task automatic test_host();
    // software asks for support before it tries to enter
    @(posedge clock);
    query_leaf <= 32'(vmc_pkg::VMC_FEAT_LEAF);
    cr4_value <= 32'h1 << vmc_pkg::VMC_CR4_VIRT_EN_BIT;
    issue(vmc_pkg::VMC_OP_FEATURE_QUERY, 64'h0);
    chk({62'h0, result_r[vmc_pkg::VMC_FEAT_BIT], fault_r}, 64'h2,
        "support while off");
    issue(vmc_pkg::VMC_OP_ENTER, 64'h0);
    chk({61'h0, done_r, fault_r, in_virt_r}, 64'h5, "enter");
    chk({63'h0, restrict_r}, 64'h0, "host unrestricted");
    issue(vmc_pkg::VMC_OP_ENTER, 64'h0);
    chk({62'h0, fault_r, in_virt_r}, 64'h3, "enter twice");
    issue(vmc_pkg::VMC_OP_STORE_PTR, 64'h0);
    chk(result_r, vmc_pkg::VMC_PTR_RST, "pointer reset");
    issue(vmc_pkg::VMC_OP_LOAD_PTR, PTR_A);
    chk({63'h0, fault_r}, 64'h0, "load pointer");
    issue(vmc_pkg::VMC_OP_STORE_PTR, 64'h0);
    chk(result_r, PTR_A, "stored pointer");
    // feature bit is set for leaf 1 only
    @(posedge clock);
    query_leaf <= 32'h1;
    issue(vmc_pkg::VMC_OP_FEATURE_QUERY, 64'h0);
    chk({63'h0, result_r[5]}, 64'h1, "feature leaf 1");
    @(posedge clock);
    query_leaf <= 32'h2;
    issue(vmc_pkg::VMC_OP_FEATURE_QUERY, 64'h0);
    chk({63'h0, result_r[5]}, 64'h0, "feature leaf 2");
    @(posedge clock);
    cap_idx <= 2'h3;
    issue(vmc_pkg::VMC_OP_READ_FIELD, 64'h0);
    chk(result_r, vmc_pkg::VMC_CAP_DFLT, "capability read");
    issue(vmc_pkg::VMC_OP_WRITE_FIELD, 64'h0);
    chk({63'h0, ctl_access_r}, 64'h1, "field write access");
    chk(ctl_addr_r, PTR_A, "field write address");
    // a flush names its own structure, not the current one
    issue(vmc_pkg::VMC_OP_FLUSH, ~PTR_A);
    chk({63'h0, ctl_access_r}, 64'h1, "flush access");
    chk(ctl_addr_r, ~PTR_A, "flush address");
    issue(vmc_pkg::VMC_OP_CALL_MONITOR, 64'h0);
    chk({63'h0, fault_r}, 64'h1, "call in host");
  endtask

  // launch, event exit at privilege 0, resume and call back to back
  task automatic test_guest();
    @(posedge clock);
    exit_entry_point <= EP_A;
    current_privilege <= 2'h0;
    issue(vmc_pkg::VMC_OP_FIRST_ENTRY, 64'h0);
    chk({61'h0, guest_entry_r, restrict_r, in_virt_r}, 64'h7,
        "first entry");
    chk(ctl_addr_r, PTR_A, "entry uses structure");
    @(posedge clock);
    guest_event <= 1'b1;
    @(posedge clock);
    guest_event <= 1'b0;
    #1;
    chk({61'h0, guest_exit_r, redirect_r, restrict_r}, 64'h6,
        "event exit");
    chk(redirect_pc_r, EP_A, "exit target");
    chk({63'h0, in_virt_r}, 64'h1, "host after exit");
    // resume and call monitor issued on consecutive cycles
    @(posedge clock);
    exit_entry_point <= ~EP_A;
    instr_valid <= 1'b1;
    instr_op <= vmc_pkg::VMC_OP_REPEAT_ENTRY;
    @(posedge clock);
    instr_op <= vmc_pkg::VMC_OP_CALL_MONITOR;
    #1;
    chk({62'h0, guest_entry_r, restrict_r}, 64'h3, "resume");
    @(posedge clock);
    instr_valid <= 1'b0;
    instr_op <= vmc_pkg::VMC_OP_NONE;
    #1;
    chk({61'h0, guest_exit_r, restrict_r, fault_r}, 64'h4,
        "call exit");
    chk(redirect_pc_r, ~EP_A, "call target");
    // a pointer load inside the guest exits and keeps the pointer
    issue(vmc_pkg::VMC_OP_REPEAT_ENTRY, 64'h0);
    issue(vmc_pkg::VMC_OP_LOAD_PTR, ~PTR_A);
    chk({61'h0, guest_exit_r, fault_r, restrict_r}, 64'h4,
        "load in guest");
    issue(vmc_pkg::VMC_OP_STORE_PTR, 64'h0);
    chk(result_r, PTR_A, "pointer kept");
  endtask

  // leave, then the pointer is out of reach again
  task automatic test_leave();
    issue(vmc_pkg::VMC_OP_LEAVE, 64'h0);
    chk({61'h0, done_r, fault_r, in_virt_r}, 64'h4, "leave");
    issue(vmc_pkg::VMC_OP_LOAD_PTR, ~PTR_A);
    chk({63'h0, fault_r}, 64'h1, "load after leave");
  endtask

  // report counts and the verdict, then stop
  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence: reset for 12 cycles, then each scenario in turn
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    test_off_faults();
    test_host();
    test_guest();
    test_leave();
    stop_test();
  end

  // watchdog: the whole run needs well under 200 cycles
  initial
  begin
    #(2000 * 5);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
